// File: design/abm_params.svh
`ifndef ABM_PARAMS_SVH
`define ABM_PARAMS_SVH
`define ABM_LOWER_W        24
`define ABM_UPPER_W        8
`define ABM_SPACE_W        4
`define ABM_SPACE_CPU      4'h7
`define ABM_PORT_RESET     8'h00
`define ABM_DIR_RESET      8'h00
`define ABM_MODE_RESET     16'h0000
`define ABM_MODE_ADDR      2'h0
`define ABM_MODE_PORT      2'h1
`define ABM_MODE_IACK      2'h2
`endif

// File: design/abm_pkg.sv
package abm_pkg;
  typedef enum logic [1:0] {
    ABM_PIN_ADDR = 2'h0,
    ABM_PIN_PORT = 2'h1,
    ABM_PIN_IACK = 2'h2,
    ABM_PIN_RSVD = 2'h3
  } abm_pin_mode_t;
  typedef enum logic [1:0] {
    ABM_IDLE,
    ABM_STROBE
  } abm_state_t;
endpackage

// File: design/abm_cycle_if.sv
`timescale 1ns/1ps
interface abm_cycle_if;
  logic        latch;
  logic        active;
  logic [31:0] address;
  logic [3:0]  space;
  logic        iack;
  logic [2:0]  level;
  modport hold (input latch, input address, input space, output active, output iack, output level);
  modport ctrl (output latch, output address, output space, input active, input iack, input level);
endinterface

// File: design/abm_cycle_hold.sv
`timescale 1ns/1ps
`include "abm_params.svh"
module abm_cycle_hold
  import abm_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic strobe_end,
  abm_cycle_if.hold cyc
);
  abm_state_t  state;
  abm_state_t  next_state;
  logic [31:0] held;
  logic [31:0] next_held;
  logic [3:0]  held_space;
  logic [3:0]  next_held_space;

  always_comb begin
    next_state      = state;
    next_held       = held;
    next_held_space = held_space;
    case (state)
      ABM_IDLE: begin
        if (cyc.latch) begin
          next_state      = ABM_STROBE;
          next_held       = cyc.address;
          next_held_space = cyc.space;
        end
      end
      default: begin
        // address frozen until strobe ends; new request ignored meanwhile
        if (strobe_end) begin
          next_state = ABM_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state      <= ABM_IDLE;
      held       <= 32'h0000_0000;
      held_space <= 4'h0;
    end else begin
      state      <= next_state;
      held       <= next_held;
      held_space <= next_held_space;
    end
  end

  assign cyc.active = (state == ABM_STROBE);
  // acknowledge cycle: cpu space, type field all ones in bits 19:16
  assign cyc.iack   = cyc.active && (held_space == `ABM_SPACE_CPU) && (held[19:16] == 4'hf)
                      && (held[3:1] != 3'h0);
  assign cyc.level  = held[3:1];
endmodule

// File: design/abm_addr_pin_mux.sv
`timescale 1ns/1ps
`include "abm_params.svh"
module abm_addr_pin_mux
  import abm_pkg::*;
#(
  parameter int LOWER_W = `ABM_LOWER_W,
  parameter int UPPER_W = `ABM_UPPER_W
)(
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               cycle_start,
  input  wire logic               cycle_end,
  input  wire logic [31:0]        cycle_address,
  input  wire logic [3:0]         space_code,
  input  wire logic               bus_owned,
  input  wire logic [15:0]        pin_mode,
  input  wire logic [UPPER_W-1:0] port_out_data,
  input  wire logic [UPPER_W-1:0] port_dir,
  input  wire logic               port_write,
  input  wire logic [UPPER_W-1:0] upper_address_lines_in,
  output logic                    address_strobe_n,
  output logic [3:0]              space_code_lines,
  output logic [LOWER_W-1:0]      lower_address_lines,
  output logic [LOWER_W-1:0]      lower_address_lines_oe,
  output logic [UPPER_W-1:0]      upper_address_lines,
  output logic [UPPER_W-1:0]      upper_address_lines_oe,
  output logic [UPPER_W-1:0]      upper_pin_parallel_port
);
  abm_cycle_if cyc ();

  // port group
  logic [UPPER_W-1:0] port_latch;
  logic [UPPER_W-1:0] next_port_latch;
  logic [UPPER_W-1:0] port_in;
  logic [UPPER_W-1:0] next_port_in;
  logic [UPPER_W-1:0] next_readback;
  // strobe and space group
  logic [3:0]         cycle_space;
  logic [3:0]         next_cycle_space;
  logic               next_strobe_n;
  logic [3:0]         next_space;
  // lower lane group
  logic [LOWER_W-1:0] next_lower;
  logic [LOWER_W-1:0] next_lower_oe;
  // upper pin group
  logic [UPPER_W-1:0] next_upper;
  logic [UPPER_W-1:0] next_upper_oe;
  logic [7:0]         ack_onehot;
  logic               take_start;

  function automatic abm_pin_mode_t mode_of(input logic [15:0] m, input int i);
    return abm_pin_mode_t'(m[2*i +: 2]);
  endfunction

  // line i reports level i+1; the top line has no level and idles negated
  function automatic logic ack_line_n(input logic [7:0] onehot, input int i);
    logic line_n;
    line_n = 1'b1;
    if (i < 7) begin
      line_n = !onehot[i + 1];
    end
    return line_n;
  endfunction

  assign cyc.latch   = cycle_start;
  assign cyc.address = cycle_address;
  assign cyc.space   = space_code;

  abm_cycle_hold u_hold (
    .clk        (clk),
    .rst_n      (rst_n),
    .strobe_end (cycle_end),
    .cyc        (cyc)
  );

  always_comb begin
    // acknowledge level n drives line n-1; level 0 never reaches here
    ack_onehot = 8'h00;
    if (cyc.iack) begin
      ack_onehot[cyc.level] = 1'b1;
    end
  end

  // a start is only taken while idle; one during a strobe is dropped
  assign take_start = cycle_start && !cyc.active;

  // port group: latch, pin sampling and readback
  always_comb begin
    next_port_latch = port_latch;
    if (port_write) begin
      next_port_latch = port_out_data;
    end
    next_port_in  = upper_address_lines_in;
    // driven pins read back the latch, inputs the pin level
    next_readback = (port_dir & port_latch) | (~port_dir & port_in);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      port_latch              <= `ABM_PORT_RESET;
      port_in                 <= '0;
      upper_pin_parallel_port <= '0;
    end else begin
      port_latch              <= next_port_latch;
      port_in                 <= next_port_in;
      upper_pin_parallel_port <= next_readback;
    end
  end

  // strobe and space group
  always_comb begin
    next_cycle_space = cycle_space;
    if (take_start) begin
      // captured with the address so the code cannot move under the strobe
      next_cycle_space = space_code;
    end
    next_strobe_n = !cyc.active;
    next_space    = 4'h0;
    if (cyc.active) begin
      next_space = cycle_space;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cycle_space      <= 4'h0;
      address_strobe_n <= 1'b1;
      space_code_lines <= 4'h0;
    end else begin
      cycle_space      <= next_cycle_space;
      address_strobe_n <= next_strobe_n;
      space_code_lines <= next_space;
    end
  end

  // lower lane group
  always_comb begin
    next_lower    = lower_address_lines;
    next_lower_oe = {LOWER_W{bus_owned}};
    // loaded only when a start is taken, so it cannot move under the strobe
    if (take_start) begin
      next_lower = cycle_address[LOWER_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lower_address_lines    <= '0;
      lower_address_lines_oe <= '0;
    end else begin
      lower_address_lines    <= next_lower;
      lower_address_lines_oe <= next_lower_oe;
    end
  end

  // upper pin group
  always_comb begin
    for (int i = 0; i < UPPER_W; i++) begin
      next_upper[i]    = 1'b0;
      next_upper_oe[i] = 1'b0;
      case (mode_of(pin_mode, i))
        ABM_PIN_ADDR: begin
          next_upper[i] = upper_address_lines[i];
          if (take_start) begin
            next_upper[i] = cycle_address[LOWER_W+i];
          end
          next_upper_oe[i] = bus_owned;
        end
        ABM_PIN_PORT: begin
          next_upper[i]    = next_port_latch[i];
          next_upper_oe[i] = port_dir[i];
        end
        ABM_PIN_IACK: begin
          // active low, always driven so a peripheral never sees a floating line
          next_upper[i]    = ack_line_n(ack_onehot, i);
          next_upper_oe[i] = 1'b1;
        end
        default: begin
          next_upper[i]    = 1'b0;
          next_upper_oe[i] = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      upper_address_lines    <= '0;
      upper_address_lines_oe <= '0;
    end else begin
      upper_address_lines    <= next_upper;
      upper_address_lines_oe <= next_upper_oe;
    end
  end
endmodule

// File: tb/abm_addr_pin_mux_properties.sv
`timescale 1ns/1ps
module abm_addr_pin_mux_props
  import abm_pkg::*;
#(
  parameter int LOWER_W = 24,
  parameter int UPPER_W = 8
)(
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic               cycle_start,
  input wire logic               cycle_end,
  input wire logic [31:0]        cycle_address,
  input wire logic [3:0]         space_code,
  input wire logic               bus_owned,
  input wire logic [15:0]        pin_mode,
  input wire logic [UPPER_W-1:0] port_out_data,
  input wire logic               port_write,
  input wire logic               address_strobe_n,
  input wire logic [LOWER_W-1:0] lower_address_lines,
  input wire logic [LOWER_W-1:0] lower_address_lines_oe,
  input wire logic [UPPER_W-1:0] upper_address_lines
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic go = cycle_start && address_strobe_n;
  addr_drive_a: assert property (
    go && space_code != 4'h7 |=> lower_address_lines == $past(cycle_address[LOWER_W-1:0]))
    else $error("lower address not driven");
  upper_addr_a: assert property (
    go && pin_mode == 16'h0000 |=> upper_address_lines == $past(cycle_address[31:24]))
    else $error("upper address not driven");
  strobe_go_a: assert property (go |-> ##2 !address_strobe_n) else $error("strobe late");
  strobe_end_a: assert property (
    cycle_end && !address_strobe_n |=> !address_strobe_n ##1 address_strobe_n)
    else $error("strobe end wrong");
  addr_hold_a: assert property (
    !address_strobe_n && $past(!address_strobe_n) |-> $stable(lower_address_lines))
    else $error("address moved under strobe");
  drv_oe_a: assert property (
    $past(rst_n) && $past(bus_owned) |-> lower_address_lines_oe == '1)
    else $error("drivers off");
  port_out_a: assert property (
    (pin_mode == 16'h5555 && port_write) ##1 (pin_mode == 16'h5555) [*3]
    |-> upper_address_lines == $past(port_out_data, 3)) else $error("port data lost");
  ack_idle_a: assert property (
    (rst_n && pin_mode == 16'haaaa && address_strobe_n) [*3] |-> upper_address_lines == '1)
    else $error("stray acknowledge");
  ack_one_a: assert property (
    (pin_mode == 16'haaaa && !address_strobe_n) [*2]
    |-> $countones(~upper_address_lines) <= 1) else $error("several acknowledges");
  cover property (go);
  cover property (cycle_end && !address_strobe_n);
  cover property (pin_mode == 16'h5555 && port_write);
endmodule
bind abm_addr_pin_mux abm_addr_pin_mux_props #(.LOWER_W(LOWER_W), .UPPER_W(UPPER_W)) u_props (.*);

// File: tb/abm_bus_peer.sv
`timescale 1ns/1ps
module abm_bus_peer (
  input  wire logic       clk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] ext_data,
  input  wire logic [7:0] ext_oe,
  output logic      [7:0] pin_in,
  output logic      [2:0] ack_level
);
  // undriven pins float: show a changing pattern, never a stale value
  logic [7:0] noise = 8'h55;
  always_ff @(posedge clk) noise <= ~noise;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_data) | (~pin_oe & ~ext_oe & noise);
  always_comb begin
    ack_level = 3'h0;
    for (int k = 6; k >= 0; k--) if (!pin_in[k]) ack_level = 3'(k + 1);
  end
endmodule

// File: tb/abm_addr_pin_mux_tb.sv
`timescale 1ns/1ps
module abm_addr_pin_mux_tb;
  import abm_pkg::*;
  typedef struct {logic [31:0] a; logic [3:0] s; logic [15:0] m; logic [7:0] up;} abm_row_t;
  logic clk = 0, rst_n = 0, cs = 0, ce = 0, bo = 1, pw = 0;
  logic [31:0] ad = 0;
  logic [3:0] sc = 0;
  logic [15:0] pm = 16'haaaa;
  logic [7:0] pd = 0, dir = 0, xd = 0, xoe = 0;
  wire logic as_n;
  wire logic [23:0] lo, lo_oe;
  wire logic [7:0] up, up_oe, pp, pin;
  wire logic [2:0] ack;
  int err_count = 0, n_tests = 0;
  abm_row_t rows [6] = '{'{32'hA5C3_0F12, 4'h5, 16'h0000, 8'hA5}, '{32'h0000_0001, 4'h1, 16'h0000, 8'h00},
    '{32'hFFFF_FFFF, 4'h6, 16'h0000, 8'hFF}, '{32'h000F_000E, 4'h7, 16'haaaa, 8'hBF},
    '{32'h000F_0002, 4'h7, 16'haaaa, 8'hFE}, '{32'h7F00_0000, 4'h5, 16'h9000, 8'hBF}};
  always #50 clk = ~clk;
  abm_addr_pin_mux DUT (.clk(clk), .rst_n(rst_n), .cycle_start(cs), .cycle_end(ce), .cycle_address(ad),
    .space_code(sc), .bus_owned(bo), .pin_mode(pm), .port_out_data(pd), .port_dir(dir), .port_write(pw),
    .upper_address_lines_in(pin), .address_strobe_n(as_n), .space_code_lines(), .lower_address_lines(lo),
    .lower_address_lines_oe(lo_oe), .upper_address_lines(up), .upper_address_lines_oe(up_oe),
    .upper_pin_parallel_port(pp));
  abm_bus_peer peer (.clk(clk), .pin_out(up), .pin_oe(up_oe), .ext_data(xd), .ext_oe(xoe), .pin_in(pin),
    .ack_level(ack));
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_as(logic v);
    for (int k = 0; k < 20 && as_n !== v; k++) tick(1);
    if (as_n !== v) begin
      err_count++;
      end_sim();
    end
  endtask
  task automatic run(abm_row_t r);
    ad = r.a; sc = r.s; pm = r.m; cs = 1;
    tick(1);
    cs = 0;
    wait_as(0);
    ad = ~r.a; cs = 1; // refused start, address must not follow
    tick(1);
    cs = 0;
    tick(1);
    chk("upper", r.up, up);
    if (r.s != 4'h7) chk("lower", r.a[23:0], lo);
    if (r.s == 4'h7) chk("ack", r.a[3:1], ack);
    ce = 1;
    tick(1);
    ce = 0;
    wait_as(1);
    chk("lower_oe", 24'hFF_FFFF, lo_oe);
    $display("bus cycle %h done", r.a);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    tick(16);
    rst_n = 1;
    tick(3);
    chk("strobe", 1, as_n);
    chk("idle_ack", 8'hFF, up);
    $display("reset done");
    foreach (rows[i]) run(rows[i]);
    pm = 16'h5555; dir = 8'hFF; pd = 8'h3C; pw = 1;
    tick(1);
    pw = 0;
    tick(3);
    chk("port", 8'h3C, up);
    run('{32'h1234_5678, 4'h5, 16'h5555, 8'h3C});
    dir = 8'h00; xd = 8'hC5; xoe = 8'hFF;
    tick(3);
    chk("readback", 8'hC5, pp);
    bo = 0;
    tick(3);
    chk("lower_oe", 0, lo_oe);
    $display("port and release done");
    end_sim();
  end
endmodule
